// ==== core/amp_fault_pkg.sv ====
// Package: register offsets, field positions and timing for the fault supervisor.
// Assumes a register port of 8-bit address and 8-bit data inside the device.
package amp_fault_pkg;
	localparam logic [7:0] OFS_DEVICE_STATE = 8'h03;
	localparam logic [7:0] OFS_SAMPLE_RATE  = 8'h37;
	localparam logic [7:0] OFS_CLOCK_DETECT = 8'h39;
	localparam logic [7:0] OFS_CHAN_FAULT   = 8'h70;
	localparam logic [7:0] OFS_GLOBAL_A     = 8'h71;
	localparam logic [7:0] OFS_GLOBAL_B     = 8'h72;
	localparam logic [7:0] OFS_FAULT_CLEAR  = 8'h78;
	localparam logic [7:0] OFS_FAULT_CONFIG = 8'h7a;
	localparam logic [1:0] STATE_HIZ        = 2'h2;
	localparam logic [1:0] STATE_PLAY       = 2'h3;
	localparam logic [7:0] DEVICE_STATE_RST = 8'h00;
	localparam int         GA_UV_BIT        = 0;
	localparam int         GA_OV_BIT        = 1;
	localparam int         GA_CLK_BIT       = 2;
	localparam int         GB_OT_BIT        = 0;
	localparam int         CFG_OT_AUTO_BIT  = 0;
	localparam int         CLOCK_PERIOD_NS  = 10;
	localparam int         DC_PERSIST_MS    = 570;
	localparam int         DC_PERSIST_CYC   = DC_PERSIST_MS * 1000000 / CLOCK_PERIOD_NS;
	localparam int         STEP_HALF_DB     = 1;
	localparam logic [7:0] VOL_MIN          = 8'hff;
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;
	typedef struct packed {
		logic clock_halt;
		logic ratio_err;
		logic pll_unlock;
		logic rate_err;
	} clock_err_t;
endpackage : amp_fault_pkg

// ==== core/channel_guard.sv ====
// Per-channel short and DC-offset guard.
// Assumes detector inputs are synchronous comparator levels.
`timescale 1ns/1ps
`default_nettype none
module channel_guard #(
	parameter int DC_CYC = amp_fault_pkg::DC_PERSIST_CYC
) (
	input  wire logic clk_in,
	input  wire logic reset_n_in,
	input  wire logic enable_in,
	input  wire logic shutdown_det_in,
	input  wire logic restart_in,
	input  wire logic dc_offset_in,
	input  wire logic clear_in,
	output logic      short_out,
	output logic      dc_fault_out,
	output logic      drive_off_out
);
	import amp_fault_pkg::*;
	logic [31:0] dc_cnt_q;
	logic        short_q;
	logic        dc_q;

	assign drive_off_out = shutdown_det_in | short_q;
	assign short_out     = short_q;
	assign dc_fault_out  = dc_q;

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			short_q <= 1'b0;
		end else if (enable_in) begin
			if (shutdown_det_in) begin
				short_q <= 1'b1;
			end else if (restart_in) begin
				short_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			dc_cnt_q <= '0;
		end else if (enable_in) begin
			if (!dc_offset_in) begin
				dc_cnt_q <= '0;
			end else if (dc_cnt_q <= 32'(DC_CYC)) begin
				dc_cnt_q <= dc_cnt_q + 32'h1;
			end
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			dc_q <= 1'b0;
		end else if (enable_in) begin
			if (dc_cnt_q > 32'(DC_CYC)) begin
				dc_q <= 1'b1;
			end else if (clear_in) begin
				dc_q <= 1'b0;
			end
		end
	end
endmodule : channel_guard
`default_nettype wire

// ==== core/amp_fault_supervisor.sv ====
// Fault supervisor and power-state sequencer for a two-channel amplifier.
// Assumes register port strobes and detector levels synchronous to clk_in.
// What this block does
// - Ramp-down lowers volume 0.5dB once per sample period.
// - Severe short shuts only the affected channel within 100 ns.
// - Overcurrent shutdown asserts fault pin, latches record; host may restart.
// - Peak-current limiting alone latches nothing, operation resumes afterwards.
// - DC offset persisting past 570ms pulls fault low, high impedance, flags.
// - DC fault bit and high impedance hold until fault clear write.
// - Over-temperature moves outputs to high impedance, flags global register.
// - Autorecovery resumes play on cooling; otherwise needs fault clear.
// - Overvoltage forces high impedance, flags; play resumes, flag sticks.
// - Undervoltage forces high impedance, flags; play resumes, flag sticks.
// - Clock errors reported live in monitor registers, force high impedance.
// - Clock fault latches bit; play resumes automatically when clocks recover.
`timescale 1ns/1ps
`default_nettype none
module amp_fault_supervisor #(
	parameter int CHANNELS = 2,
	parameter int DC_CYC   = amp_fault_pkg::DC_PERSIST_CYC
) (
	input  wire logic                     clk_in,
	input  wire logic                     reset_n_in,
	input  wire logic                     clk_en_in,
	input  wire logic                     power_down_pin_n_in,
	input  wire amp_fault_pkg::reg_req_t  reg_req_in,
	output logic [7:0]                    reg_rdata_out,
	input  wire logic                     sample_tick_in,
	input  wire logic [CHANNELS-1:0]      shutdown_det_in,
	input  wire logic [CHANNELS-1:0]      peak_limit_in,
	input  wire logic [CHANNELS-1:0]      dc_offset_in,
	input  wire logic                     over_temp_in,
	input  wire logic                     temp_cooled_in,
	input  wire logic                     supply_over_in,
	input  wire logic                     supply_over_ok_in,
	input  wire logic                     supply_under_in,
	input  wire logic                     supply_under_ok_in,
	input  wire amp_fault_pkg::clock_err_t clock_err_in,
	input  wire logic [3:0]               rate_code_in,
	output logic [CHANNELS-1:0]           speaker_outputs_en_out,
	output logic [CHANNELS-1:0]           current_limit_out,
	output logic [7:0]                    volume_atten_out,
	output logic                          fault_n_out
);
	import amp_fault_pkg::*;

	typedef enum logic [1:0] {ST_HIZ, ST_PLAY, ST_RAMP} out_state_t;

	out_state_t          state_q;
	logic [7:0]          dev_state_q;
	logic [7:0]          cfg_q;
	logic [7:0]          vol_q;
	logic                ot_q, ot_hold_q, ov_q, ov_act_q, uv_q, uv_act_q, clk_q;
	logic [CHANNELS-1:0] short_w, dc_w, off_w, restart_w;
	logic                clear_w, clk_err_w, hold_hiz_w, play_ok_w, wr_state_w;
	logic [7:0]          rdata_d;

	// ----------------------------------------
	// Register port
	// ----------------------------------------
	// A write to OFS_FAULT_CLEAR clears latches
	assign clear_w    = reg_req_in.wr && reg_req_in.addr == OFS_FAULT_CLEAR;
	assign wr_state_w = reg_req_in.wr && reg_req_in.addr == OFS_DEVICE_STATE;
	assign clk_err_w  = |clock_err_in;

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			dev_state_q <= DEVICE_STATE_RST;
			cfg_q       <= '0;
		end else if (clk_en_in) begin
			if (wr_state_w) begin
				dev_state_q <= reg_req_in.wdata;
			end
			if (reg_req_in.wr && reg_req_in.addr == OFS_FAULT_CONFIG) begin
				cfg_q <= reg_req_in.wdata;
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < CHANNELS; g++) begin : g_ch
			assign restart_w[g] = clear_w | (wr_state_w && reg_req_in.wdata[g]);
			channel_guard #(.DC_CYC(DC_CYC)) u_guard (
				.clk_in          (clk_in),
				.reset_n_in      (reset_n_in),
				.enable_in       (clk_en_in),
				.shutdown_det_in (shutdown_det_in[g]),
				.restart_in      (restart_w[g]),
				.dc_offset_in    (dc_offset_in[g]),
				.clear_in        (clear_w),
				.short_out       (short_w[g]),
				.dc_fault_out    (dc_w[g]),
				.drive_off_out   (off_w[g])
			);
		end
	endgenerate

	// ----------------------------------------
	// Global faults
	// ----------------------------------------
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			ot_q <= 1'b0;
			ot_hold_q <= 1'b0;
		end else if (clk_en_in) begin
			if (over_temp_in) begin
				ot_q      <= 1'b1;
				ot_hold_q <= 1'b1;
			end else begin
				if (clear_w) begin
					ot_q <= 1'b0;
				end
				if ((cfg_q[CFG_OT_AUTO_BIT] && temp_cooled_in) || clear_w) begin
					ot_hold_q <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			ov_q <= 1'b0;
			ov_act_q <= 1'b0;
			uv_q <= 1'b0;
			uv_act_q <= 1'b0;
			clk_q <= 1'b0;
		end else if (clk_en_in) begin
			if (supply_over_in) begin
				ov_act_q <= 1'b1;
			end else if (supply_over_ok_in) begin
				ov_act_q <= 1'b0;
			end
			if (supply_over_in) begin
				ov_q <= 1'b1;
			end else if (clear_w) begin
				ov_q <= 1'b0;
			end
			if (supply_under_in) begin
				uv_act_q <= 1'b1;
			end else if (supply_under_ok_in) begin
				uv_act_q <= 1'b0;
			end
			if (supply_under_in) begin
				uv_q <= 1'b1;
			end else if (clear_w) begin
				uv_q <= 1'b0;
			end
			if (clk_err_w) begin
				clk_q <= 1'b1;
			end else if (clear_w) begin
				clk_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Output state
	// ----------------------------------------
	// Clock error forces high impedance
	assign hold_hiz_w = ot_hold_q | ov_act_q | uv_act_q | clk_err_w | (|dc_w);
	assign play_ok_w  = power_down_pin_n_in && dev_state_q[1:0] == STATE_PLAY && !hold_hiz_w;

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state_q <= ST_HIZ;
			vol_q   <= VOL_MIN;
		end else if (clk_en_in) begin
			case (state_q)
				ST_HIZ: begin
					vol_q <= VOL_MIN;
					if (play_ok_w) begin
						state_q <= ST_PLAY;
						vol_q   <= '0;
					end
				end
				ST_PLAY: begin
					// Faults cut at once; a plain state request ramps first
					if (hold_hiz_w || !power_down_pin_n_in) begin
						state_q <= ST_HIZ;
					end else if (dev_state_q[1:0] != STATE_PLAY) begin
						state_q <= ST_RAMP;
					end
				end
				ST_RAMP: begin
					if (hold_hiz_w || !power_down_pin_n_in || vol_q == VOL_MIN) begin
						state_q <= ST_HIZ;
					end else if (sample_tick_in) begin
						vol_q <= vol_q + 8'(STEP_HALF_DB);
					end
				end
				default: state_q <= ST_HIZ;
			endcase
		end
	end

	// Peak limiting passes through, no latch
	assign current_limit_out = peak_limit_in;
	assign speaker_outputs_en_out = (state_q != ST_HIZ) ? ~off_w : '0;
	assign volume_atten_out = vol_q;
	// Fault line low on latched short or DC faults
	assign fault_n_out = ~((|short_w) | (|dc_w));

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	always_comb begin
		rdata_d = '0;
		case (reg_req_in.addr)
			OFS_DEVICE_STATE: rdata_d = dev_state_q;
			OFS_SAMPLE_RATE:  rdata_d = {4'h0, rate_code_in};
			OFS_CLOCK_DETECT: rdata_d = {4'h0, clock_err_in};
			OFS_CHAN_FAULT:   rdata_d = {2'(dc_w), 4'h0, 2'(short_w)};
			OFS_GLOBAL_A: begin
				rdata_d[GA_UV_BIT]  = uv_q;
				rdata_d[GA_OV_BIT]  = ov_q;
				rdata_d[GA_CLK_BIT] = clk_q;
			end
			OFS_GLOBAL_B:     rdata_d[GB_OT_BIT] = ot_q;
			OFS_FAULT_CONFIG: rdata_d = cfg_q;
			default:          rdata_d = '0;
		endcase
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			reg_rdata_out <= '0;
		end else if (clk_en_in && reg_req_in.rd) begin
			reg_rdata_out <= rdata_d;
		end
	end
endmodule : amp_fault_supervisor
`default_nettype wire

// ==== tb/amp_fault_asserts.sv ====
// Checker: fault and timing relations at the supervisor ports.
// Assumes clk_en_in held high while properties are judged.
`timescale 1ns/1ps
`default_nettype none
module amp_fault_asserts
	import amp_fault_pkg::*;
#(
	parameter int CHANNELS = 2,
	parameter int DC_CYC   = 20
) (
	input wire logic                         clk_in,
	input wire logic                         reset_n_in,
	input wire logic                         clk_en_in,
	input wire logic                         power_down_pin_n_in,
	input wire amp_fault_pkg::reg_req_t      reg_req_in,
	input wire logic [7:0]                   reg_rdata_out,
	input wire logic                         sample_tick_in,
	input wire logic [CHANNELS-1:0]          shutdown_det_in,
	input wire logic [CHANNELS-1:0]          peak_limit_in,
	input wire logic [CHANNELS-1:0]          dc_offset_in,
	input wire logic                         over_temp_in,
	input wire logic                         temp_cooled_in,
	input wire logic                         supply_over_in,
	input wire logic                         supply_over_ok_in,
	input wire logic                         supply_under_in,
	input wire logic                         supply_under_ok_in,
	input wire amp_fault_pkg::clock_err_t    clock_err_in,
	input wire logic [3:0]                   rate_code_in,
	input wire logic [CHANNELS-1:0]          speaker_outputs_en_out,
	input wire logic [CHANNELS-1:0]          current_limit_out,
	input wire logic [7:0]                   volume_atten_out,
	input wire logic                         fault_n_out
);
	// ----------------
	// Properties
	// ----------------
	default clocking @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);
	// Saturates so a long offset cannot wrap
	logic [31:0] dc_run_q;
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) dc_run_q <= '0;
		else if (!dc_offset_in[0]) dc_run_q <= '0;
		else if (dc_run_q < DC_CYC + 4) dc_run_q <= dc_run_q + 32'h1;
	end
	sequence s_over2; supply_over_in [*2]; endsequence
	sequence s_rate_rd; reg_req_in.rd && reg_req_in.addr == OFS_SAMPLE_RATE; endsequence
	// Writes that may legally release the fault pin
	logic held_clr_w;
	assign held_clr_w = reg_req_in.wr
		&& (reg_req_in.addr == OFS_FAULT_CLEAR || reg_req_in.addr == OFS_DEVICE_STATE);
	a_limit_follow: assert property (current_limit_out == peak_limit_in)
		else $error("current limit differs from peak detector");
	a_short_off: assert property (!(|(shutdown_det_in & speaker_outputs_en_out)))
		else $error("shorted channel still driving");
	a_dc_trip: assert property (dc_run_q == DC_CYC + 4
		|-> !fault_n_out && !(|speaker_outputs_en_out))
		else $error("persistent offset not tripped");
	a_dc_hold: assert property (!fault_n_out && !held_clr_w |=> !fault_n_out)
		else $error("fault pin released without clear");
	// Latch takes one edge and the output state one more
	a_ov_hiz: assert property (s_over2 |=> speaker_outputs_en_out == '0)
		else $error("overvoltage left outputs driving");
	a_uv_hiz: assert property (supply_under_in ##1 supply_under_in |=> !(|speaker_outputs_en_out))
		else $error("undervoltage left outputs driving");
	a_clk_hiz: assert property ($past(|clock_err_in) && (|clock_err_in)
		|-> !(|speaker_outputs_en_out))
		else $error("clock error left outputs driving");
	a_ot_hiz: assert property (over_temp_in [*2] |=> speaker_outputs_en_out == '0)
		else $error("over temperature left outputs driving");
	a_pdn_hiz: assert property ((!power_down_pin_n_in) [*2] |-> speaker_outputs_en_out == '0)
		else $error("power down pin left outputs driving");
	a_rate_read: assert property (s_rate_rd |=> reg_rdata_out == {4'h0, $past(rate_code_in)})
		else $error("rate monitor read wrong");
	a_vol_ramp: assert property ($changed(volume_atten_out)
		&& volume_atten_out != 8'h00 && volume_atten_out != VOL_MIN
		|-> volume_atten_out == $past(volume_atten_out) + 8'h01 && $past(sample_tick_in))
		else $error("volume step not one per sample");
endmodule : amp_fault_asserts
bind amp_fault_supervisor amp_fault_asserts #(.CHANNELS(CHANNELS), .DC_CYC(DC_CYC)) chk (.*);
`default_nettype wire

// ==== tb/host_model.sv ====
// Host model: register master that keeps the host-side power order.
// Assumes strobes are taken at the rising edge; delays scaled by MS_CYC.
`timescale 1ns/1ps
`default_nettype none
module host_model
	import amp_fault_pkg::*;
#(
	parameter int MS_CYC = 200
) (
	input  wire logic                 clk_in,
	input  wire logic [7:0]           rdata_in,
	output amp_fault_pkg::reg_req_t   req_out
);
	// ----------------
	// Bus cycles
	// ----------------
	initial req_out = '0;
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_in);
		req_out = {2'b10, a, d};
		@(negedge clk_in);
		// Idle lines show the inverse, not stale values
		req_out = {2'b00, ~a, ~d};
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk_in);
		req_out = {2'b01, a, 8'h00};
		@(negedge clk_in);
		d = rdata_in;
		req_out = {2'b00, ~a, 8'hff};
	endtask : rd
	task automatic wait_ms(input int n);
		repeat (n * MS_CYC) @(negedge clk_in);
	endtask : wait_ms
	task automatic start_play();
		wait_ms(5);
		wr(OFS_DEVICE_STATE, {6'h0, STATE_HIZ});
		wait_ms(5);
		wr(OFS_DEVICE_STATE, {6'h0, STATE_PLAY});
	endtask : start_play
	task automatic stop();
		wr(OFS_DEVICE_STATE, {6'h0, STATE_HIZ});
		wait_ms(6);
	endtask : stop
endmodule : host_model
`default_nettype wire

// ==== tb/tb.sv ====
// Testbench: play, faults, recovery and shutdown of the supervisor.
// Assumes host_model as master; offset persistence shortened to DCC.
`timescale 1ns/1ps
`default_nettype none
module tb;
	import amp_fault_pkg::*;
	localparam int DCC = 20;
	logic clk_in = 0, reset_n_in = 0, power_down_pin_n = 0, ot = 0, fault_n;
	logic [1:0] tc = 0, sd = 0, pk = 0, dc = 0, en, lim;
	logic [2:0] f = 0;
	logic [3:0] rate = 4'h5;
	logic [7:0] rdata, vol, r;
	reg_req_t req;
	int n_mismatch = 0, compares = 0;
	always #5 clk_in = ~clk_in;
	always @(negedge clk_in) tc <= tc + 2'h1;
	host_model #(.MS_CYC(200)) host (.clk_in(clk_in), .rdata_in(rdata), .req_out(req));
	amp_fault_supervisor #(.DC_CYC(DCC)) uut (.clk_in(clk_in), .reset_n_in(reset_n_in),
		.clk_en_in(1'b1), .power_down_pin_n_in(power_down_pin_n), .reg_req_in(req), .reg_rdata_out(rdata),
		.sample_tick_in(tc == 2'h0), .shutdown_det_in(sd), .peak_limit_in(pk),
		.dc_offset_in(dc), .over_temp_in(ot), .temp_cooled_in(!ot), .supply_over_in(f[1]),
		.supply_over_ok_in(!f[1]), .supply_under_in(f[0]), .supply_under_ok_in(!f[0]),
		.clock_err_in({f[2], 3'h0}), .rate_code_in(rate), .speaker_outputs_en_out(en),
		.current_limit_out(lim), .volume_atten_out(vol), .fault_n_out(fault_n));
	// ----------------
	// Shared tasks
	// ----------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_in);
	endtask : cyc
	task automatic close_out();
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : close_out
	// ----------------
	// Scenarios
	// ----------------
	task automatic t_regs();
		host.rd(OFS_DEVICE_STATE, r);
		chk(r, DEVICE_STATE_RST);
		host.wr(OFS_CHAN_FAULT, 8'hff);
		host.rd(OFS_CHAN_FAULT, r);
		chk(r, 8'h00);
		host.rd(8'h10, r);
		chk(r, 8'h00);
		host.rd(OFS_SAMPLE_RATE, r);
		chk(r, {4'h0, rate});
		$display("t_regs done");
	endtask : t_regs
	task automatic t_short();
		host.start_play();
		cyc(1);
		chk({6'h0, en}, 8'h03);
		pk = 2'h1;
		sd = 2'h2;
		#1 chk({4'h0, lim, en}, 8'h05);
		cyc(2);
		sd = 2'h0;
		pk = 2'h0;
		host.rd(OFS_CHAN_FAULT, r);
		chk({r[6:0], fault_n}, 8'h04);
		host.wr(OFS_DEVICE_STATE, {6'h0, STATE_PLAY});
		cyc(1);
		chk({5'h0, fault_n, en}, 8'h07);
		$display("t_short done");
	endtask : t_short
	task automatic t_dc();
		dc = 2'h1;
		cyc(DCC + 4);
		chk({5'h0, fault_n, en}, 8'h00);
		host.rd(OFS_CHAN_FAULT, r);
		chk(r, 8'h40);
		dc = 2'h0;
		host.wr(OFS_DEVICE_STATE, {6'h0, STATE_PLAY});
		cyc(3);
		chk({5'h0, fault_n, en}, 8'h00);
		host.wr(OFS_FAULT_CLEAR, 8'h00);
		host.rd(OFS_CHAN_FAULT, r);
		chk(r, 8'h00);
		host.wr(OFS_DEVICE_STATE, {6'h0, STATE_PLAY});
		cyc(1);
		chk({5'h0, fault_n, en}, 8'h07);
		$display("t_dc done");
	endtask : t_dc
	task automatic t_supply();
		for (int k = 0; k < 3; k++) begin
			f = 3'h1 << k;
			cyc(2);
			chk({6'h0, en}, 8'h00);
			host.rd(OFS_CLOCK_DETECT, r);
			chk(r, {4'h0, f[2], 3'h0});
			f = 3'h0;
			cyc(3);
			chk({6'h0, en}, 8'h03);
			host.rd(OFS_GLOBAL_A, r);
			chk(r, 8'h01 << k);
			host.wr(OFS_FAULT_CLEAR, 8'h00);
			host.rd(OFS_GLOBAL_A, r);
			chk(r, 8'h00);
		end
		$display("t_supply done");
	endtask : t_supply
	task automatic t_ot();
		host.wr(OFS_FAULT_CONFIG, 8'h01);
		ot = 1'b1;
		cyc(2);
		chk({6'h0, en}, 8'h00);
		host.rd(OFS_GLOBAL_B, r);
		chk(r, 8'h01);
		ot = 1'b0;
		cyc(3);
		chk({6'h0, en}, 8'h03);
		host.wr(OFS_FAULT_CONFIG, 8'h00);
		ot = 1'b1;
		cyc(2);
		ot = 1'b0;
		cyc(3);
		chk({6'h0, en}, 8'h00);
		host.wr(OFS_FAULT_CLEAR, 8'h00);
		cyc(2);
		chk({6'h0, en}, 8'h03);
		$display("t_ot done");
	endtask : t_ot
	task automatic t_stop();
		host.stop();
		chk({6'h0, en}, 8'h00);
		chk(vol, VOL_MIN);
		host.start_play();
		cyc(1);
		chk(vol, 8'h00);
		power_down_pin_n = 1'b0;
		cyc(3);
		chk({6'h0, en}, 8'h00);
		host.wr(OFS_DEVICE_STATE, {6'h0, STATE_HIZ});
		power_down_pin_n = 1'b1;
		host.start_play();
		host.wr(OFS_DEVICE_STATE, {6'h0, STATE_HIZ});
		cyc(8);
		chk({6'h0, en}, 8'h03);
		power_down_pin_n = 1'b0;
		cyc(2);
		chk({6'h0, en}, 8'h00);
		$display("t_stop done");
	endtask : t_stop
	initial begin
		repeat (4) @(negedge clk_in);
		reset_n_in = 1'b1;
		chk({fault_n, 1'b0, en, 4'h0}, 8'h80);
		power_down_pin_n = 1'b1;
		t_regs();
		t_short();
		t_dc();
		t_supply();
		t_ot();
		t_stop();
		close_out();
	end
	// Runs well past the expected total of some 7350 cycles
	initial begin
		#300us;
		n_mismatch++;
		close_out();
	end
endmodule : tb
`default_nettype wire
